// *** verilog/wps_pkg.sv ***
// Constants, field layouts and types of the wake and power-state controller
package wps_pkg;

	// Clock and timing figures
	localparam int unsigned CLK_NS         = 8;       // 125 MHz period
	localparam int unsigned NS_PER_MS      = 1000000;
	localparam int unsigned DEBOUNCE_MS    = 10;      // Least stable time
	localparam int unsigned SHORT_PRESS_MS = 4000;    // Longest short press
	localparam int unsigned FORCE_OFF_MS   = 6000;    // Least forcing hold
	localparam int unsigned ONBOARD_OFF_MS = 3000;    // Onboard button hold
	// Cycle counts: least times round up, longest times round down
	localparam int unsigned DB_CYC    = 32'((longint'(DEBOUNCE_MS) * NS_PER_MS
		+ CLK_NS - 1) / CLK_NS);
	localparam int unsigned SHORT_CYC = 32'((longint'(SHORT_PRESS_MS)
		* NS_PER_MS) / CLK_NS);
	localparam int unsigned OFF_CYC   = 32'((longint'(FORCE_OFF_MS) * NS_PER_MS
		+ CLK_NS - 1) / CLK_NS);
	localparam int unsigned ONB_CYC   = 32'((longint'(ONBOARD_OFF_MS)
		* NS_PER_MS + CLK_NS - 1) / CLK_NS);

	// Widths
	localparam int unsigned NUM_FANS = 4;
	localparam int unsigned DUTY_W   = 8;
	localparam int unsigned TACH_W   = 16;
	localparam int unsigned PRESS_W  = 30;
	localparam int unsigned DB_W     = 21;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_CMD       = 8'h04;
	localparam logic [7:0] REG_STATUS    = 8'h08;
	localparam logic [7:0] REG_RTC_NOW   = 8'h0c;
	localparam logic [7:0] REG_RTC_ALARM = 8'h10;
	localparam logic [7:0] REG_FAN_DUTY  = 8'h14;
	localparam logic [7:0] REG_TACH_LO   = 8'h18;
	localparam logic [7:0] REG_TACH_HI   = 8'h1c;

	// Control fields and reset values
	localparam int unsigned CTRL_PME_EN   = 0;
	localparam int unsigned CTRL_BICOLOUR = 1;
	localparam int unsigned CTRL_RESTORE  = 2;   // Two bits
	localparam int unsigned CTRL_RTC_ARM  = 4;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0008;
	localparam logic [31:0] DUTY_RESET     = 32'h8080_8080;
	localparam logic [1:0]  RESTORE_OFF    = 2'h0;
	localparam logic [1:0]  RESTORE_ON     = 2'h1;

	// Status fields
	localparam int unsigned STAT_RAIL    = 3;
	localparam int unsigned STAT_LAST_ON = 4;
	localparam int unsigned STAT_PEND    = 8;

	// State codes seen by software
	localparam logic [2:0] SCODE_S0 = 3'h0;
	localparam logic [2:0] SCODE_S1 = 3'h1;
	localparam logic [2:0] SCODE_S3 = 3'h3;
	localparam logic [2:0] SCODE_S4 = 3'h4;
	localparam logic [2:0] SCODE_S5 = 3'h5;
	localparam logic [2:0] SCODE_G3 = 3'h7;

	// Filtered input and wake source indices
	localparam int unsigned IN_USB  = 0;
	localparam int unsigned IN_PME  = 1;
	localparam int unsigned IN_PCIE = 2;
	localparam int unsigned IN_IR   = 3;
	localparam int unsigned IN_LAN  = 4;
	localparam int unsigned IN_FBTN = 5;
	localparam int unsigned IN_OBTN = 6;
	localparam int unsigned IN_N    = 7;
	localparam int unsigned WK_RTC  = 5;
	localparam int unsigned WK_N    = 6;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Power states
	typedef enum logic [2:0] {ST_G3, ST_S0, ST_S1, ST_S3, ST_S4, ST_S5}
		wps_state_t;

endpackage

// *** verilog/wps_db_if.sv ***
// Raw and filtered input bundle between the controller and its filter
`timescale 1ns/100ps
`default_nettype none
interface wps_db_if;
	import wps_pkg::*;
	logic [IN_N-1:0] raw;    // Active-high raw inputs
	logic [IN_N-1:0] level;  // Filtered levels
	logic [IN_N-1:0] rise;   // One-cycle pulse on filtered rise
	modport owner (input raw, output level, output rise);
	modport user  (output raw, input level, input rise);
endinterface
`default_nettype wire

// *** verilog/wps_debounce.sv ***
// Synchroniser and debounce filter for wake and button inputs
`timescale 1ns/100ps
`default_nettype none
module wps_debounce
	import wps_pkg::*;
#(
	parameter int unsigned DB_CYCLES = DB_CYC
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	wps_db_if.owner   db
);

	logic [IN_N-1:0] s1_q;  // First sync stage
	logic [IN_N-1:0] s2_q;  // Second sync stage

	// Two-stage synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= db.raw;
			s2_q <= s1_q;
		end
	end

	// Per-input stability counter
	for (genvar i = 0; i < IN_N; i++) begin : g_bit
		logic [DB_W-1:0] cnt_q;  // Cycles of disagreement
		logic            lvl_q;  // Filtered level
		logic            rise_q; // Rise pulse
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cnt_q  <= '0;
				lvl_q  <= 1'b0;
				rise_q <= 1'b0;
			end else if (s2_q[i] != lvl_q) begin
				// Accept only after a full stable window
				if (cnt_q == DB_W'(DB_CYCLES - 1)) begin
					cnt_q  <= '0;
					lvl_q  <= s2_q[i];
					rise_q <= s2_q[i];
				end else begin
					cnt_q  <= cnt_q + 1'b1;
					rise_q <= 1'b0;
				end
			end else begin
				cnt_q  <= '0;
				rise_q <= 1'b0;
			end
		end
		assign db.level[i] = lvl_q;
		assign db.rise[i]  = rise_q;

		// A rise pulse always comes with a high level
		a_rise_has_level: assert property (@(posedge aclk)
			disable iff (!aresetn) db.rise[i] |-> db.level[i])
			else $error("rise pulse without high level");
	end

endmodule
`default_nettype wire

// *** verilog/wps_top.sv ***
// Wake and power-state controller with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
module wps_top
	import wps_pkg::*;
#(
	parameter int unsigned DB_CYCLES    = DB_CYC,
	parameter int unsigned SHORT_CYCLES = SHORT_CYC,
	parameter int unsigned OFF_CYCLES   = OFF_CYC,
	parameter int unsigned ONB_CYCLES   = ONB_CYC
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                usb_activity,
	input  wire logic                pme_n,
	input  wire logic                pcie_wake_n,
	input  wire logic                infrared_remote_activity,
	input  wire logic                lan_wake_req,
	input  wire logic                front_btn_n,
	input  wire logic                onboard_btn_n,
	input  wire logic                ac_ok,
	input  wire logic                rtc_sec_tick,
	input  wire logic                cpu_hot,
	input  wire logic                vr_hot,
	input  wire logic                sata_activity,
	input  wire logic [NUM_FANS-1:0] fan_tach,
	output logic                     main_rail_en,
	output logic [NUM_FANS-1:0]      fan_en,
	output logic [NUM_FANS-1:0]      fan_pwm,
	output logic                     pwr_led_green,
	output logic                     pwr_led_amber,
	output logic                     stby_led,
	output logic                     cpu_hot_led,
	output logic                     vr_hot_led,
	output logic                     hdd_led
);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wps_db_if db ();                      // Filter bundle
	wps_state_t          state_q;         // Power state
	logic                last_on_q;       // Was working at AC loss
	logic [WK_N-1:0]     pend_q;          // Latched wake requests
	logic [WK_N-1:0]     wake_set;        // Qualified wake events
	logic [31:0]         ctrl_q;          // Control register
	logic [31:0]         rtc_now_q;       // Seconds counter
	logic [31:0]         rtc_alarm_q;     // Wake time
	logic [31:0]         duty_q;          // Four 8-bit duties
	logic                cmd_valid_q;     // OS command pulse
	logic [2:0]          cmd_code_q;      // Requested state
	logic [PRESS_W-1:0]  press_cnt_q;     // Hold duration
	logic                btn_prev_q;      // Held last cycle
	logic                long_done_q;     // Forcing hold fired
	logic                force_off_q;     // Force soft-off pulse
	logic                short_q;         // Short press pulse
	logic [DUTY_W-1:0]   pwm_cnt_q;       // PWM ramp
	logic [TACH_W-1:0]   tach_cnt [NUM_FANS]; // Tach edge counts
	logic                awready_q, wready_q, bvalid_q;
	logic                arready_q, rvalid_q;
	logic [1:0]          bresp_q, rresp_q;
	logic [31:0]         rdata_q, rd_data;
	logic                rd_hit, wr_hit;
	logic [7:0]          aw_addr_q;       // Captured write address
	logic [31:0]         w_data_q;        // Captured write data
	logic [3:0]          w_strb_q;        // Captured byte enables
	logic                wr_go;           // Both halves present
	logic                rail_q, green_q, amber_q, stby_q;
	logic                cpu_led_q, vr_led_q, hdd_q;
	logic [NUM_FANS-1:0] fan_en_q, fan_pwm_q;
	logic                is_work, is_sleep, btn_held, rtc_hit;
	logic [PRESS_W-1:0]  off_lim;
	logic [2:0]          scode;

	// Merge write data under byte enables
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	// Active-high raw inputs into the filter
	assign db.raw[IN_USB]  = usb_activity;
	assign db.raw[IN_PME]  = ~pme_n;
	assign db.raw[IN_PCIE] = ~pcie_wake_n;
	assign db.raw[IN_IR]   = infrared_remote_activity;
	assign db.raw[IN_LAN]  = lan_wake_req;
	assign db.raw[IN_FBTN] = ~front_btn_n;
	assign db.raw[IN_OBTN] = ~onboard_btn_n;

	wps_debounce #(.DB_CYCLES(DB_CYCLES)) u_db (
		.aclk    (aclk),
		.aresetn (aresetn),
		.db      (db)
	);

	// State classes
	assign is_work  = (state_q == ST_S0) || (state_q == ST_S1);
	assign is_sleep = (state_q == ST_S1) || (state_q == ST_S3)
		|| (state_q == ST_S4) || (state_q == ST_S5);
	assign rtc_hit  = ctrl_q[CTRL_RTC_ARM] && (rtc_now_q == rtc_alarm_q);

	// Wake qualification per source and state
	assign wake_set[IN_USB]  = db.rise[IN_USB]
		&& ((state_q == ST_S1) || (state_q == ST_S3));
	assign wake_set[IN_PME]  = db.rise[IN_PME] && is_sleep
		&& ctrl_q[CTRL_PME_EN];
	assign wake_set[IN_PCIE] = db.rise[IN_PCIE] && is_sleep;
	assign wake_set[IN_IR]   = db.rise[IN_IR] && is_sleep
		&& (state_q != ST_S1);
	assign wake_set[IN_LAN]  = db.rise[IN_LAN] && is_sleep;
	assign wake_set[WK_RTC]  = rtc_hit && is_sleep;

	// Latch wake requests; a set wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_q <= '0;
		end else if (!is_sleep) begin
			pend_q <= wake_set;
		end else begin
			pend_q <= pend_q | wake_set;
		end
	end

	// Button hold timing; forcing hold is ONB_CYCLES while onboard held, else OFF_CYCLES
	assign btn_held = db.level[IN_FBTN] || db.level[IN_OBTN];
	assign off_lim  = db.level[IN_OBTN] ? PRESS_W'(ONB_CYCLES)
		: PRESS_W'(OFF_CYCLES);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			press_cnt_q <= '0;
			btn_prev_q  <= 1'b0;
			long_done_q <= 1'b0;
			force_off_q <= 1'b0;
			short_q     <= 1'b0;
		end else begin
			btn_prev_q  <= btn_held;
			force_off_q <= 1'b0;
			short_q     <= 1'b0;
			if (btn_held) begin
				// Saturating hold counter
				if (press_cnt_q != '1) press_cnt_q <= press_cnt_q + 1'b1;
				if (!long_done_q && press_cnt_q >= off_lim - 1'b1) begin
					force_off_q <= 1'b1;
					long_done_q <= 1'b1;
				end
			end else begin
				press_cnt_q <= '0;
				long_done_q <= 1'b0;
				// Short press acts on release
				if (btn_prev_q && !long_done_q
					&& press_cnt_q < PRESS_W'(SHORT_CYCLES)) begin
					short_q <= 1'b1;
				end
			end
		end
	end

	// Power state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_G3;
		end else if (!ac_ok) begin
			state_q <= ST_G3;
		end else if (force_off_q && state_q != ST_G3) begin
			state_q <= ST_S5;
		end else begin
			case (state_q)
				ST_G3: begin
					// AC returned: apply restore policy
					if (ctrl_q[CTRL_RESTORE +: 2] == RESTORE_OFF) begin
						state_q <= ST_S5;
					end else if (ctrl_q[CTRL_RESTORE +: 2] == RESTORE_ON) begin
						state_q <= ST_S0;
					end else begin
						state_q <= last_on_q ? ST_S0 : ST_S5;
					end
				end
				ST_S0: begin
					if (cmd_valid_q) begin
						case (cmd_code_q)
							SCODE_S1: state_q <= ST_S1;
							SCODE_S3: state_q <= ST_S3;
							SCODE_S4: state_q <= ST_S4;
							SCODE_S5: state_q <= ST_S5;
							default:  state_q <= ST_S0;
						endcase
					end else if (short_q) begin
						state_q <= ST_S3;
					end
				end
				default: begin
					// Sleeping or soft-off: wake to working
					if (|pend_q || short_q) state_q <= ST_S0;
				end
			endcase
		end
	end

	// Remember on/off across an AC loss
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_on_q <= 1'b0;
		end else if (!ac_ok && state_q != ST_G3) begin
			last_on_q <= is_work;
		end
	end

	// Registered pin outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rail_q    <= 1'b0;
			fan_en_q  <= '0;
			green_q   <= 1'b0;
			amber_q   <= 1'b0;
			stby_q    <= 1'b0;
			cpu_led_q <= 1'b0;
			vr_led_q  <= 1'b0;
			hdd_q     <= 1'b0;
		end else begin
			rail_q    <= is_work;
			fan_en_q  <= {NUM_FANS{is_work}};
			green_q   <= is_work;
			amber_q   <= (state_q == ST_S3) && ctrl_q[CTRL_BICOLOUR];
			stby_q    <= 1'b1;
			cpu_led_q <= cpu_hot;
			vr_led_q  <= vr_hot;
			hdd_q     <= sata_activity;
		end
	end

	// PWM ramp shared by all fans
	always_ff @(posedge aclk) begin
		if (!aresetn) pwm_cnt_q <= '0;
		else          pwm_cnt_q <= pwm_cnt_q + 1'b1;
	end

	// Per-fan tach counting and PWM drive
	for (genvar i = 0; i < NUM_FANS; i++) begin : g_fan
		logic t1_q, t2_q, t3_q;  // Tach sync and edge stage
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				t1_q         <= 1'b0;
				t2_q         <= 1'b0;
				t3_q         <= 1'b0;
				tach_cnt[i]  <= '0;
				fan_pwm_q[i] <= 1'b0;
			end else begin
				t1_q <= fan_tach[i];
				t2_q <= t1_q;
				t3_q <= t2_q;
				if (t2_q && !t3_q) tach_cnt[i] <= tach_cnt[i] + 1'b1;
				fan_pwm_q[i] <= is_work
					&& (pwm_cnt_q < duty_q[DUTY_W*i +: DUTY_W]);
			end
		end
	end

	// AXI write address and data capture, response
	assign wr_go  = !awready_q && !wready_q && !bvalid_q;
	assign wr_hit = aw_addr_q[7:5] == 3'h0 && aw_addr_q[1:0] == 2'h0
		&& aw_addr_q != REG_STATUS && aw_addr_q != REG_TACH_LO
		&& aw_addr_q != REG_TACH_HI;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				awready_q <= 1'b0;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q) begin
				wready_q <= 1'b0;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// Software-written registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q      <= CTRL_RESET;
			duty_q      <= DUTY_RESET;
			rtc_alarm_q <= '0;
			rtc_now_q   <= '0;
			cmd_valid_q <= 1'b0;
			cmd_code_q  <= SCODE_S0;
		end else begin
			cmd_valid_q <= 1'b0;
			if (wr_go && aw_addr_q == REG_CTRL)
				ctrl_q <= wmerge(ctrl_q, w_data_q, w_strb_q);
			if (wr_go && aw_addr_q == REG_FAN_DUTY)
				duty_q <= wmerge(duty_q, w_data_q, w_strb_q);
			if (wr_go && aw_addr_q == REG_RTC_ALARM)
				rtc_alarm_q <= wmerge(rtc_alarm_q, w_data_q, w_strb_q);
			// Setting the clock overrides a tick
			if (wr_go && aw_addr_q == REG_RTC_NOW)
				rtc_now_q <= wmerge(rtc_now_q, w_data_q, w_strb_q);
			else if (rtc_sec_tick)
				rtc_now_q <= rtc_now_q + 1'b1;
			if (wr_go && aw_addr_q == REG_CMD && w_strb_q[0]) begin
				cmd_valid_q <= 1'b1;
				cmd_code_q  <= w_data_q[2:0];
			end
		end
	end

	// Software code of the current state
	always_comb begin
		case (state_q)
			ST_S0:   scode = SCODE_S0;
			ST_S1:   scode = SCODE_S1;
			ST_S3:   scode = SCODE_S3;
			ST_S4:   scode = SCODE_S4;
			ST_S5:   scode = SCODE_S5;
			default: scode = SCODE_G3;
		endcase
	end

	// Read decode
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = '0;
		if (s_axi_araddr == REG_CTRL) begin
			rd_data = ctrl_q;
		end else if (s_axi_araddr == REG_CMD) begin
			rd_data = {29'h0, cmd_code_q};
		end else if (s_axi_araddr == REG_STATUS) begin
			rd_data = {18'h0, pend_q, 3'h0, last_on_q, rail_q, scode};
		end else if (s_axi_araddr == REG_RTC_NOW) begin
			rd_data = rtc_now_q;
		end else if (s_axi_araddr == REG_RTC_ALARM) begin
			rd_data = rtc_alarm_q;
		end else if (s_axi_araddr == REG_FAN_DUTY) begin
			rd_data = duty_q;
		end else if (s_axi_araddr == REG_TACH_LO) begin
			rd_data = {tach_cnt[1], tach_cnt[0]};
		end else if (s_axi_araddr == REG_TACH_HI) begin
			rd_data = {tach_cnt[3], tach_cnt[2]};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// AXI read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_data;
			rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// Output wiring from flip-flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign main_rail_en  = rail_q;
	assign fan_en        = fan_en_q;
	assign fan_pwm       = fan_pwm_q;
	assign pwr_led_green = green_q;
	assign pwr_led_amber = amber_q;
	assign stby_led      = stby_q;
	assign cpu_hot_led   = cpu_led_q;
	assign vr_hot_led    = vr_led_q;
	assign hdd_led       = hdd_q;

	// Checks
	sequence s_off_cmd;
		state_q == ST_S0 && cmd_valid_q && cmd_code_q == SCODE_S5
			&& ac_ok && !force_off_q;
	endsequence
	sequence s_restore_on;
		state_q == ST_G3 && ac_ok && last_on_q
			&& ctrl_q[CTRL_RESTORE +: 2] > RESTORE_ON;
	endsequence
	a_fans_on_work: assert property (is_work |=> fan_en_q == '1)
		else $error("fans not on in working state");
	a_fans_off_sleep: assert property (!is_work |=> fan_en_q == '0)
		else $error("fans on while off or deep sleep");
	a_off_cmd_rails: assert property (s_off_cmd |=>
		state_q == ST_S5 ##1 !main_rail_en && fan_en == '0)
		else $error("off command did not drop rails");
	a_ac_restore_on: assert property (s_restore_on |=>
		state_q == ST_S0 ##1 main_rail_en)
		else $error("last on state not restored");
	a_usb_no_deep: assert property (state_q == ST_S5
		&& !pend_q[IN_USB] |=> !pend_q[IN_USB])
		else $error("usb wake latched in soft-off");
	a_pme_gated: assert property (state_q == ST_S5 && db.rise[IN_PME]
		&& !ctrl_q[CTRL_PME_EN] && !pend_q[IN_PME] |=> !pend_q[IN_PME])
		else $error("pme wake taken while disabled");
	a_ir_not_s1: assert property (state_q == ST_S1 && !pend_q[IN_IR]
		|=> !pend_q[IN_IR])
		else $error("infrared wake latched in S1");
	a_s3_led_rail: assert property (state_q == ST_S3 |=>
		!main_rail_en && !pwr_led_green
		&& pwr_led_amber == $past(ctrl_q[CTRL_BICOLOUR]))
		else $error("S3 rail or led wrong");
	a_s3_wake_s0: assert property (state_q == ST_S3 && |pend_q
		&& ac_ok && !force_off_q |=> state_q == ST_S0)
		else $error("wake from S3 did not return to S0");
	a_force_off: assert property (force_off_q && ac_ok
		&& state_q != ST_G3 |=> state_q == ST_S5)
		else $error("forced off not taken");
	a_stby_led_lit: assert property (aresetn |=> stby_led)
		else $error("standby led dark");
	a_hdd_follows: assert property (hdd_led == $past(sata_activity))
		else $error("drive led not following activity");
	a_pwm_gated: assert property (fan_pwm[0] |-> fan_en[0])
		else $error("pwm active with fan disabled");

endmodule
`default_nettype wire

// *** tb/wps_periph.sv ***
// Model of the wake-capable peripherals and the two buttons
`timescale 1ns/100ps
`default_nettype none
module wps_periph (
	input  wire logic       aclk,
	input  wire logic [2:0] sel,
	input  wire logic       go,
	input  wire logic [6:0] len,
	output logic      [6:0] act
);
	logic [6:0] cnt_q = 7'h00; // Cycles the event lasts
	logic [2:0] cur_q = 3'h0;  // Line being held
	// Start or run down one held event
	always @(posedge aclk) begin
		if (go) begin
			cur_q <= sel;
			cnt_q <= len;
		end else if (cnt_q != 7'h00) begin
			cnt_q <= cnt_q - 7'h01;
		end
	end
	// One line at a time; the adapter raises its request so
	assign act = (cnt_q != 7'h00) ? 7'h01 << cur_q : 7'h00;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the wake and power-state controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import wps_pkg::*;
	logic aclk = 0, aresetn = 0, ac_ok = 1, rtc_sec_tick = 0, go = 0, lo = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, cpu_hot = 0, vr_hot = 0;
	logic sata_activity = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, main_rail_en, pwr_led_green;
	logic pwr_led_amber, stby_led, cpu_hot_led, vr_hot_led, hdd_led;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] fan_en, fan_pwm;
	logic [2:0] sel = 0;
	logic [6:0] len = 0, act;
	logic [33:0] q[$]; // Expected read answers
	logic [1:0] bq[$]; // Expected write answers
	logic [3:0] tach = 4'h0, strb = 4'hf; // Tach lines, byte enables
	int pc[4]; // PWM high cycles per fan
	int num_errors = 0, n_checks = 0, seed = 62709;
	wps_periph PER (.aclk, .sel, .go, .len, .act);
	wps_top #(.DB_CYCLES(4), .SHORT_CYCLES(40), .OFF_CYCLES(60),
		.ONB_CYCLES(30)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(strb), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .usb_activity(act[0]),
		.pme_n(!act[1]), .pcie_wake_n(!act[2]),
		.infrared_remote_activity(act[3]), .lan_wake_req(act[4]),
		.front_btn_n(!act[5]), .onboard_btn_n(!act[6]), .ac_ok,
		.rtc_sec_tick, .cpu_hot, .vr_hot, .sata_activity, .fan_tach(tach),
		.main_rail_en, .fan_en, .fan_pwm, .pwr_led_green, .pwr_led_amber,
		.stby_led, .cpu_hot_led, .vr_hot_led, .hdd_led);
	// Clock
	always #4 aclk = ~aclk;
	// Compare and count
	task automatic cmp(input logic [33:0] e, input logic [33:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: exp %h got %h", $time, e, g);
		end
	endtask
	// Oldest note against each read answer
	always @(posedge aclk)
		if (s_axi_rvalid && s_axi_rready)
			cmp(q.pop_front(), {s_axi_rresp, s_axi_rdata});
	// Oldest note against each write answer
	always @(posedge aclk)
		if (s_axi_bvalid && s_axi_bready)
			cmp(34'(bq.pop_front()), 34'(s_axi_bresp));
	// Bus write
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e = RESP_OKAY);
		bq.push_back(e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	// Bus read with its expected answer noted
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	// Status, rail and fans for state code c
	task automatic st(input logic [2:0] c);
		logic r;
		r = (c == SCODE_S0) || (c == SCODE_S1);
		rd(REG_STATUS, {RESP_OKAY, 27'h0, lo, r, c});
		cmp(34'(fan_en), r ? 34'hf : 34'h0);
		cmp(34'(main_rail_en), 34'(r));
	endtask
	// Far side holds one line for n cycles
	task automatic ev(input int unsigned s, n, input logic [2:0] c);
		sel <= 3'(s);
		len <= 7'(n);
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (90) @(posedge aclk);
		st(c);
	endtask
	// Operating system state command
	task automatic cm(input logic [2:0] c);
		wr(REG_CMD, 32'(c));
		repeat (8) @(posedge aclk);
		st(c);
	endtask
	// AC loss and return, then state c with last-on flag l
	task automatic acx(input logic l, input logic [2:0] c);
		ac_ok <= 1'b0;
		repeat (4) @(posedge aclk);
		ac_ok <= 1'b1;
		lo = l;
		repeat (8) @(posedge aclk);
		st(c);
	endtask
	// Verdict
	task automatic final_report;
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		#100000;
		num_errors++;
		final_report;
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		cmp(34'(stby_led), 34'h1);
		rd(REG_CTRL, {RESP_OKAY, CTRL_RESET});
		rd(REG_FAN_DUTY, {RESP_OKAY, DUTY_RESET});
		st(SCODE_S5);
		wr(REG_STATUS, 32'h0, RESP_SLVERR);
		wr(REG_CTRL, 32'h0000_000a);
		ev(IN_PME, 12, SCODE_S5);
		ev(IN_FBTN, 12, SCODE_S0);
		cm(SCODE_S3);
		cmp(34'({pwr_led_amber, pwr_led_green}), 34'h2);
		ev(IN_USB, 12, SCODE_S0);
		cm(SCODE_S1);
		ev(IN_IR, 12, SCODE_S1);
		ev(IN_PCIE, 12, SCODE_S0);
		cm(SCODE_S4);
		ev(IN_USB, 12, SCODE_S4);
		ev(IN_LAN, 12, SCODE_S0);
		cm(SCODE_S5);
		ev(IN_PCIE, 2, SCODE_S5);
		wr(REG_RTC_ALARM, 32'h3);
		wr(REG_RTC_NOW, 32'h0);
		wr(REG_CTRL, 32'h0000_0019);
		repeat (3) begin
			rtc_sec_tick <= 1'b1;
			@(posedge aclk);
			rtc_sec_tick <= 1'b0;
			@(posedge aclk);
		end
		repeat (8) @(posedge aclk);
		st(SCODE_S0);
		wr(REG_FAN_DUTY, 32'h4010_c020);
		repeat (256) begin
			@(posedge aclk);
			for (int f = 0; f < 4; f++) pc[f] += fan_pwm[f];
		end
		for (int f = 0; f < 4; f++)
			cmp(34'(pc[f]), 34'(8'(32'h4010_c020 >> (8 * f))));
		strb <= 4'h1;
		wr(REG_FAN_DUTY, 32'hffff_ff00);
		strb <= 4'hf;
		rd(REG_FAN_DUTY, {RESP_OKAY, 32'h4010_c000});
		wr(REG_CTRL, 32'h0000_0009);
		ev(IN_OBTN, 50, SCODE_S5);
		ev(IN_PME, 12, SCODE_S0);
		acx(1'b1, SCODE_S0);
		wr(REG_CTRL, 32'h0000_0001);
		acx(1'b1, SCODE_S5);
		wr(REG_CTRL, 32'h0000_0005);
		acx(1'b0, SCODE_S0);
		rd(8'h20, {RESP_SLVERR, 32'h0});
		repeat (3) begin
			tach <= 4'h5;
			repeat (2) @(posedge aclk);
			tach <= 4'h0;
			repeat (2) @(posedge aclk);
		end
		rd(REG_TACH_LO, {RESP_OKAY, 32'h0000_0003});
		rd(REG_TACH_HI, {RESP_OKAY, 32'h0000_0003});
		repeat (8) begin
			{cpu_hot, vr_hot, sata_activity} <= 3'($random(seed));
			repeat (3) @(posedge aclk);
			cmp(34'({cpu_hot_led, vr_hot_led, hdd_led}),
				34'({cpu_hot, vr_hot, sata_activity}));
		end
		final_report;
	end
endmodule
`default_nettype wire
